// ### hw/eeprom_host_pkg.sv
package eeprom_host_pkg;

   // control byte layout
   localparam logic [3:0] TYPE_CODE = 4'hA;
   localparam logic       RW_READ   = 1'b1;
   localparam logic       RW_WRITE  = 1'b0;
   localparam logic [2:0] ADDR_PAD  = 3'h0;
   localparam logic [2:0] SEL_NONE  = 3'h0;

   // bit engine: four quarter phases per scl period, nine bits per byte
   localparam logic [1:0] PH_DRIVE  = 2'h0;
   localparam logic [1:0] PH_RISE   = 2'h1;
   localparam logic [1:0] PH_SAMPLE = 2'h2;
   localparam logic [1:0] PH_LAST   = 2'h3;
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   localparam logic [3:0] ACK_BIT       = 4'h8;

   // timing: 100 kHz scl from the 50 MHz system clock
   localparam int unsigned MCLK_PERIOD_NS = 20;
   localparam int unsigned SCL_QUARTER_NS = 2500;
   localparam int unsigned QUARTER_CYC    = (SCL_QUARTER_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam logic [6:0]  QUARTER_LAST   = 7'(QUARTER_CYC - 1);
   localparam int unsigned TWC_MS         = 5;
   localparam int unsigned TWC_CYC        = (TWC_MS * 1000000) / MCLK_PERIOD_NS;
   localparam int unsigned WAIT_W         = 24;

   localparam int unsigned PAGE_AW = 5;

   typedef enum logic [3:0] {
      ST_IDLE   = 4'h0,
      ST_START  = 4'h1,
      ST_CTRLW  = 4'h3,
      ST_ADRH   = 4'h2,
      ST_ADRL   = 4'h6,
      ST_WDATA  = 4'h7,
      ST_RSTART = 4'h5,
      ST_CTRLR  = 4'h4,
      ST_RDATA  = 4'hC,
      ST_STOP   = 4'hD,
      ST_WAIT   = 4'hF
   } state_t;

   typedef struct packed {
      logic        rd;
      logic        cur;
      logic [2:0]  sel;
      logic [12:0] addr;
      logic [4:0]  len;
   } cmd_t;

   typedef struct packed {
      state_t              st;
      logic [1:0]          ph;
      logic [6:0]          qcnt;
      logic [3:0]          bitn;
      logic [7:0]          sr;
      logic [4:0]          wcnt;
      logic [4:0]          ld_ptr;
      cmd_t                cmd;
      logic                scl_oe;
      logic                sda_oe;
      logic                sda_s1;
      logic                sda_s2;
      logic                scl_s1;
      logic                scl_s2;
      logic                ack_hi;
      logic                nack;
      logic                done;
      logic                rvalid;
      logic [7:0]          rdat;
      logic                prot;
      logic [WAIT_W-1:0]   wait_cnt;
   } core_t;

endpackage

// ### hw/page_buf.sv
`timescale 1ns/100ps
module page_buf (
   input  wire logic                                 clk_i,
   input  wire logic                                 wr_en_i,
   input  wire logic [eeprom_host_pkg::PAGE_AW-1:0]  wr_addr_i,
   input  wire logic [7:0]                           wr_data_i,
   input  wire logic [eeprom_host_pkg::PAGE_AW-1:0]  rd_addr_i,
   output logic      [7:0]                           rd_data_o
);

   logic [7:0] mem [0:(1 << eeprom_host_pkg::PAGE_AW)-1];

   // no reset: a byte is only sent after the user has loaded it
   always_ff @(posedge clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem[rd_addr_i];
   end

endmodule

// ### hw/eeprom_host.sv
`timescale 1ns/100ps
module eeprom_host #(
   parameter int unsigned TWC_CYCLES  = eeprom_host_pkg::TWC_CYC,
   parameter logic [2:0]  DEV_SEL     = 3'h0,
   parameter bit          NO_SEL_PINS = 1'b0
) (
   input  wire logic                  MCLK_I,
   input  wire logic                  NRST_I,
   input  wire logic                  CMD_VALID_I,
   input  wire eeprom_host_pkg::cmd_t CMD_I,
   output logic                       CMD_READY_O,
   input  wire logic                  WDAT_VALID_I,
   input  wire logic [7:0]            WDAT_I,
   output logic                       WDAT_READY_O,
   output logic                       RDAT_VALID_O,
   output logic [7:0]                 RDAT_O,
   output logic                       DONE_O,
   output logic                       NACK_O,
   input  wire logic                  PROTECT_I,
   output logic                       PROTECT_O,
   output logic                       SELECT_PIN_0_O,
   output logic                       SELECT_PIN_1_O,
   output logic                       SELECT_PIN_2_O,
   input  wire logic                  SCL_I,
   output logic                       SCL_O,
   output logic                       SCL_OE_O,
   input  wire logic                  SDA_I,
   output logic                       SDA_O,
   output logic                       SDA_OE_O
);

   eeprom_host_pkg::core_t r;
   eeprom_host_pkg::core_t n;

   logic                                tick;
   logic                                bus_free;
   logic                                idle;
   logic                                tx_st;
   logic                                last;
   logic                                cmd_fire;
   logic [7:0]                          mem_q;
   logic [eeprom_host_pkg::PAGE_AW-1:0] rd_addr;

   assign idle     = (r.st == eeprom_host_pkg::ST_IDLE);
   assign bus_free = r.scl_s2 & r.sda_s2;
   assign tick     = (r.qcnt == eeprom_host_pkg::QUARTER_LAST);
   assign last     = (r.wcnt == r.cmd.len);
   assign tx_st    = (r.st == eeprom_host_pkg::ST_CTRLW) | (r.st == eeprom_host_pkg::ST_ADRH) |
                     (r.st == eeprom_host_pkg::ST_ADRL)  | (r.st == eeprom_host_pkg::ST_WDATA) |
                     (r.st == eeprom_host_pkg::ST_CTRLR);

   // waiting out the write cycle keeps commands off the bus while the part ignores us
   assign CMD_READY_O  = idle & bus_free;
   assign WDAT_READY_O = idle;
   assign cmd_fire     = CMD_VALID_I & CMD_READY_O;

   // the next page byte is fetched a whole byte ahead of its use
   assign rd_addr = (r.st == eeprom_host_pkg::ST_WDATA) ? r.wcnt + 5'h1 : r.wcnt;

   page_buf u_page (
      .clk_i     (MCLK_I),
      .wr_en_i   (WDAT_VALID_I & idle),
      .wr_addr_i (r.ld_ptr),
      .wr_data_i (WDAT_I),
      .rd_addr_i (rd_addr),
      .rd_data_o (mem_q)
   );

   always_comb begin
      n        = r;
      n.sda_s1 = SDA_I;
      n.scl_s1 = SCL_I;
      n.sda_s2 = r.sda_s1;
      n.scl_s2 = r.scl_s1;
      n.done   = 1'b0;
      n.rvalid = 1'b0;
      case (r.st)
         eeprom_host_pkg::ST_IDLE: begin
            n.prot = PROTECT_I;
            if (WDAT_VALID_I) begin
               n.ld_ptr = r.ld_ptr + 5'h1;
            end
            if (cmd_fire) begin
               n.cmd    = CMD_I;
               if (NO_SEL_PINS) begin
                  n.cmd.sel = eeprom_host_pkg::SEL_NONE;
               end
               n.nack   = 1'b0;
               n.wcnt   = 5'h0;
               n.ld_ptr = 5'h0;
               n.bitn   = 4'h0;
               n.ph     = eeprom_host_pkg::PH_DRIVE;
               n.qcnt   = 7'h0;
               n.st     = eeprom_host_pkg::ST_START;
            end
         end
         eeprom_host_pkg::ST_WAIT: begin
            if (r.wait_cnt == '0) begin
               n.st = eeprom_host_pkg::ST_IDLE;
            end else begin
               n.wait_cnt = r.wait_cnt - 1'b1;
            end
         end
         default: begin
            if (!tick) begin
               n.qcnt = r.qcnt + 7'h1;
            end else begin
               n.qcnt = 7'h0;
               n.ph   = r.ph + 2'h1;
               case (r.ph)
                  eeprom_host_pkg::PH_DRIVE: begin
                     // scl has been low a full quarter before sda moves
                     case (r.st)
                        eeprom_host_pkg::ST_START,
                        eeprom_host_pkg::ST_RSTART: n.sda_oe = 1'b0;
                        eeprom_host_pkg::ST_STOP:   n.sda_oe = 1'b1;
                        eeprom_host_pkg::ST_RDATA: begin
                           // ack all but the final byte of a read
                           n.sda_oe = (r.bitn == eeprom_host_pkg::ACK_BIT) & ~last;
                        end
                        default: begin
                           n.sda_oe = (r.bitn != eeprom_host_pkg::ACK_BIT) & ~r.sr[7];
                        end
                     endcase
                  end
                  eeprom_host_pkg::PH_SAMPLE: begin
                     case (r.st)
                        eeprom_host_pkg::ST_START,
                        eeprom_host_pkg::ST_RSTART: n.sda_oe = 1'b1;
                        eeprom_host_pkg::ST_STOP:   n.sda_oe = 1'b0;
                        eeprom_host_pkg::ST_RDATA: begin
                           if (r.bitn != eeprom_host_pkg::ACK_BIT) begin
                              n.sr = {r.sr[6:0], r.sda_s2};
                           end
                           if (r.bitn == eeprom_host_pkg::LAST_DATA_BIT) begin
                              n.rdat   = {r.sr[6:0], r.sda_s2};
                              n.rvalid = 1'b1;
                           end
                        end
                        default: begin
                           if (r.bitn == eeprom_host_pkg::ACK_BIT) begin
                              n.ack_hi = r.sda_s2;
                           end
                        end
                     endcase
                  end
                  eeprom_host_pkg::PH_LAST: begin
                     case (r.st)
                        eeprom_host_pkg::ST_START,
                        eeprom_host_pkg::ST_RSTART: begin
                           n.bitn = 4'h0;
                           n.st   = ((r.st == eeprom_host_pkg::ST_RSTART) | (r.cmd.rd & r.cmd.cur)) ?
                                    eeprom_host_pkg::ST_CTRLR : eeprom_host_pkg::ST_CTRLW;
                        end
                        eeprom_host_pkg::ST_STOP: begin
                           n.done = 1'b1;
                           if (!r.cmd.rd && !r.nack) begin
                              n.st       = eeprom_host_pkg::ST_WAIT;
                              n.wait_cnt = eeprom_host_pkg::WAIT_W'(TWC_CYCLES - 1);
                           end else begin
                              n.st = eeprom_host_pkg::ST_IDLE;
                           end
                        end
                        default: begin
                           if (r.bitn != eeprom_host_pkg::ACK_BIT) begin
                              n.bitn = r.bitn + 4'h1;
                              if (tx_st) begin
                                 n.sr = {r.sr[6:0], 1'b0};
                              end
                           end else begin
                              n.bitn = 4'h0;
                              if (tx_st && r.ack_hi) begin
                                 // no ack: wrong select, or part busy programming
                                 n.nack = 1'b1;
                                 n.st   = eeprom_host_pkg::ST_STOP;
                              end else begin
                                 case (r.st)
                                    eeprom_host_pkg::ST_CTRLW: n.st = eeprom_host_pkg::ST_ADRH;
                                    eeprom_host_pkg::ST_ADRH:  n.st = eeprom_host_pkg::ST_ADRL;
                                    eeprom_host_pkg::ST_ADRL: begin
                                       n.st = r.cmd.rd ? eeprom_host_pkg::ST_RSTART : eeprom_host_pkg::ST_WDATA;
                                    end
                                    eeprom_host_pkg::ST_CTRLR: n.st = eeprom_host_pkg::ST_RDATA;
                                    default: begin
                                       // write pages are capped at 32 bytes by the length field
                                       if (last) begin
                                          n.st = eeprom_host_pkg::ST_STOP;
                                       end else begin
                                          n.wcnt = r.wcnt + 5'h1;
                                       end
                                    end
                                 endcase
                              end
                           end
                        end
                     endcase
                     // reload only at a byte boundary, else the shift above is undone
                     case ((n.bitn == 4'h0) ? n.st : eeprom_host_pkg::ST_IDLE)
                        eeprom_host_pkg::ST_CTRLW: begin
                           n.sr = {eeprom_host_pkg::TYPE_CODE, n.cmd.sel, eeprom_host_pkg::RW_WRITE};
                        end
                        eeprom_host_pkg::ST_CTRLR: begin
                           n.sr = {eeprom_host_pkg::TYPE_CODE, n.cmd.sel, eeprom_host_pkg::RW_READ};
                        end
                        eeprom_host_pkg::ST_ADRH: begin
                           n.sr = {eeprom_host_pkg::ADDR_PAD, r.cmd.addr[12:8]};
                        end
                        eeprom_host_pkg::ST_ADRL:  n.sr = r.cmd.addr[7:0];
                        eeprom_host_pkg::ST_WDATA: n.sr = mem_q;
                        default: n.sr = n.sr;
                     endcase
                  end
                  default: n.sda_oe = r.sda_oe;
               endcase
            end
         end
      endcase
      // only this end drives scl, low in the first half of every bit
      if (n.st == eeprom_host_pkg::ST_IDLE || n.st == eeprom_host_pkg::ST_WAIT) begin
         n.scl_oe = 1'b0;
         n.sda_oe = 1'b0;
      end else begin
         n.scl_oe = (n.ph == eeprom_host_pkg::PH_DRIVE) | (n.ph == eeprom_host_pkg::PH_RISE);
      end
   end

   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // select pins are parameter levels, defined from reset on
   assign SELECT_PIN_0_O = DEV_SEL[0];
   assign SELECT_PIN_1_O = DEV_SEL[1];
   assign SELECT_PIN_2_O = DEV_SEL[2];
   assign PROTECT_O      = r.prot;

   assign SCL_O        = 1'b0;
   assign SDA_O        = 1'b0;
   assign SCL_OE_O     = r.scl_oe;
   assign SDA_OE_O     = r.sda_oe;
   assign RDAT_VALID_O = r.rvalid;
   assign RDAT_O       = r.rdat;
   assign DONE_O       = r.done;
   assign NACK_O       = r.nack;

endmodule

// ### test/eeprom_host_chk.sv
`timescale 1ns/100ps
module eeprom_host_chk #(
   parameter logic [2:0] DEV_SEL = 3'h0
) (
   input wire logic MCLK_I,
   input wire logic NRST_I,
   input wire logic CMD_VALID_I,
   input wire logic CMD_READY_O,
   input wire logic WDAT_READY_O,
   input wire logic RDAT_VALID_O,
   input wire logic DONE_O,
   input wire logic NACK_O,
   input wire logic PROTECT_I,
   input wire logic PROTECT_O,
   input wire logic SELECT_PIN_0_O,
   input wire logic SELECT_PIN_1_O,
   input wire logic SELECT_PIN_2_O,
   input wire logic SCL_OE_O,
   input wire logic SDA_OE_O
);
   localparam logic [8:0] HALF = 9'(2 * eeprom_host_pkg::QUARTER_CYC);
   logic [8:0] low_cnt_r;
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (!NRST_I);
   // length of each low phase of scl, checked to be exactly two quarters
   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) low_cnt_r <= 9'h000;
      else low_cnt_r <= SCL_OE_O ? low_cnt_r + 9'h001 : 9'h000;
   end
   property p_scl_low; $fell(SCL_OE_O) |-> low_cnt_r == HALF; endproperty
   a_scl_low: assert property (p_scl_low) else $error("scl low phase length wrong");
   property p_start; CMD_VALID_I && CMD_READY_O |-> ##[370:385] ($rose(SDA_OE_O) && !SCL_OE_O); endproperty
   a_start: assert property (p_start) else $error("no start after take");
   property p_stop; $fell(SDA_OE_O) && !SCL_OE_O |-> ##[1:130] DONE_O; endproperty
   a_stop: assert property (p_stop) else $error("stop without done");
   property p_done; DONE_O |-> !SCL_OE_O && !SDA_OE_O ##1 !DONE_O; endproperty
   a_done: assert property (p_done) else $error("done with bus held");
   property p_idle; CMD_READY_O |-> !SCL_OE_O && !SDA_OE_O && WDAT_READY_O; endproperty
   a_idle: assert property (p_idle) else $error("ready while bus busy");
   property p_sep; $changed(SCL_OE_O) |-> $stable(SDA_OE_O); endproperty
   a_sep: assert property (p_sep) else $error("sda moved with scl edge");
   property p_nack; $rose(NACK_O) |-> ##[1:800] ($fell(SDA_OE_O) && !SCL_OE_O); endproperty
   a_nack: assert property (p_nack) else $error("no stop after missing ack");
   property p_frz; !WDAT_READY_O && !$past(WDAT_READY_O) |-> $stable(PROTECT_O); endproperty
   a_frz: assert property (p_frz) else $error("protect moved mid command");
   property p_prot; $past(CMD_READY_O) |-> PROTECT_O == $past(PROTECT_I); endproperty
   a_prot: assert property (p_prot) else $error("protect not followed");
   property p_sel; {SELECT_PIN_2_O, SELECT_PIN_1_O, SELECT_PIN_0_O} == DEV_SEL; endproperty
   a_sel: assert property (p_sel) else $error("select pins wrong");
   c_take: cover property (CMD_VALID_I && CMD_READY_O);
   c_nack: cover property ($rose(NACK_O));
   c_rdat: cover property (RDAT_VALID_O);
   c_done: cover property (DONE_O);
endmodule
bind eeprom_host eeprom_host_chk #(.DEV_SEL(DEV_SEL)) chk (
   .MCLK_I(MCLK_I), .NRST_I(NRST_I), .CMD_VALID_I(CMD_VALID_I), .CMD_READY_O(CMD_READY_O),
   .WDAT_READY_O(WDAT_READY_O), .RDAT_VALID_O(RDAT_VALID_O), .DONE_O(DONE_O), .NACK_O(NACK_O),
   .PROTECT_I(PROTECT_I), .PROTECT_O(PROTECT_O), .SELECT_PIN_0_O(SELECT_PIN_0_O),
   .SELECT_PIN_1_O(SELECT_PIN_1_O), .SELECT_PIN_2_O(SELECT_PIN_2_O), .SCL_OE_O(SCL_OE_O),
   .SDA_OE_O(SDA_OE_O));

// ### test/eeprom_dev.sv
`timescale 1ns/100ps
module eeprom_dev #(
   parameter int TWC_NS = 150000
) (
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   input  wire logic [2:0] sel_i,
   input  wire logic       wp_i,
   output logic            sda_oe_o
);
   logic [7:0]  mem [0:8191];
   logic [7:0]  pg [0:31];
   logic [7:0]  sh;
   logic [12:0] adr;
   logic [5:0]  cnt;
   logic [4:0]  wi;
   logic [3:0]  bitc;
   logic [2:0]  st;
   logic        mack, busy;
   event        wstart;
   initial begin
      for (int i = 0; i < 8192; i++) mem[i] = 8'hFF;
      {sda_oe_o, st, busy, bitc, mack, adr} = '0;
   end
   always @(negedge sda_i) if (scl_i) begin
      st = 3'h1;
      bitc = 4'h0;
   end
   always @(posedge sda_i) if (scl_i) begin
      if (st == 3'h4 && cnt != 6'h00 && !(wp_i && adr[12:11] == 2'h3)) begin
         for (int i = 0; i < 32; i++)
            if (i < cnt) mem[{adr[12:5], 5'(adr[4:0] + i)}] = pg[i];
         ->wstart;
      end
      st = 3'h0;
   end
   // self-timed write, far below the 5 ms ceiling
   always @(wstart) begin
      busy = 1'b1;
      #(TWC_NS) busy = 1'b0;
   end
   always @(posedge scl_i) if (st != 3'h0) begin
      if (bitc == 4'h8) begin
         bitc = 4'h0;
         if (mack) begin
            adr = adr + 13'h0001;
            if (sda_i) st = 3'h0;
         end
      end else begin
         sh = {sh[6:0], sda_i};
         bitc = bitc + 4'h1;
      end
   end
   always @(negedge scl_i) if (st != 3'h0) begin
      sda_oe_o = 1'b0;
      mack = 1'b0;
      if (bitc == 4'h8) begin
         case (st)
            3'h1: if (sh[7:4] == 4'hA && sh[3:1] == sel_i && !busy) st = sh[0] ? 3'h5 : 3'h2;
               else st = 3'h0;
            3'h2: begin adr[12:8] = sh[4:0]; st = 3'h3; end
            3'h3: begin adr[7:0] = sh; st = 3'h4; cnt = '0; wi = '0; end
            3'h4: begin pg[wi] = sh; wi = wi + 5'h01; if (cnt < 6'h20) cnt = cnt + 6'h01; end
            default: mack = 1'b1;
         endcase
         sda_oe_o = (st != 3'h0) && !mack;
      end else if (st == 3'h5) sda_oe_o = !mem[adr][3'h7 - bitc[2:0]];
   end
endmodule

// ### test/testbench.sv
`timescale 1ns/100ps
module testbench;
   typedef struct {
      eeprom_host_pkg::cmd_t cmd;
      logic [7:0]            d0, r0, r1;
      logic                  nk;
   } row_t;
   logic clk, nrst, cmd_valid, cmd_ready, wdat_valid, wdat_ready, rdat_valid, done, nack;
   logic prot_in, prot_out, scl_oe, sda_oe, dev_oe, scl, sda, scl_o, sda_o;
   logic [7:0] wdat, rdat;
   logic [2:0] sel;
   eeprom_host_pkg::cmd_t cmd;
   logic [7:0] rq [$];
   int n_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   row_t rows [5] = '{
      '{'{1'b0, 1'b0, 3'h5, 13'h0123, 5'h00}, 8'hA5, 8'h00, 8'h00, 1'b0},
      '{'{1'b1, 1'b0, 3'h5, 13'h0123, 5'h01}, 8'h00, 8'h00, 8'h00, 1'b1},
      '{'{1'b1, 1'b0, 3'h5, 13'h0123, 5'h01}, 8'h00, 8'hA5, 8'hFF, 1'b0},
      '{'{1'b0, 1'b0, 3'h2, 13'h0123, 5'h00}, 8'h11, 8'h00, 8'h00, 1'b1},
      '{'{1'b1, 1'b1, 3'h5, 13'h0000, 5'h00}, 8'h00, 8'hFF, 8'h00, 1'b0}};
   assign scl = !scl_oe;
   assign sda = !(sda_oe || dev_oe);
   eeprom_host #(.TWC_CYCLES(20), .DEV_SEL(3'h5), .NO_SEL_PINS(1'b0)) DUT (
      .MCLK_I(clk), .NRST_I(nrst), .CMD_VALID_I(cmd_valid), .CMD_I(cmd), .CMD_READY_O(cmd_ready),
      .WDAT_VALID_I(wdat_valid), .WDAT_I(wdat), .WDAT_READY_O(wdat_ready), .RDAT_VALID_O(rdat_valid),
      .RDAT_O(rdat), .DONE_O(done), .NACK_O(nack), .PROTECT_I(prot_in), .PROTECT_O(prot_out),
      .SELECT_PIN_0_O(sel[0]), .SELECT_PIN_1_O(sel[1]), .SELECT_PIN_2_O(sel[2]), .SCL_I(scl),
      .SCL_O(scl_o), .SCL_OE_O(scl_oe), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe));
   eeprom_dev #(.TWC_NS(150000)) dev (.scl_i(scl), .sda_i(sda), .sel_i(sel), .wp_i(prot_out),
      .sda_oe_o(dev_oe));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(negedge clk) if (rdat_valid === 1'b1) rq.push_back(rdat);
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 100000) begin
         n_errors++;
         finish_test();
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic take(input eeprom_host_pkg::cmd_t c, input logic [7:0] d);
      while (cmd_ready !== 1'b1) @(posedge clk);
      @(posedge clk) #1;
      wdat_valid = 1'b1;
      wdat = d;
      @(posedge clk) #1;
      wdat_valid = 1'b0;
      cmd_valid = 1'b1;
      cmd = c;
      rq.delete();
      @(posedge clk) #1;
      cmd_valid = 1'b0;
   endtask
   task automatic finish_test();
      if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      {nrst, cmd_valid, wdat_valid, prot_in, wdat, cmd} = '0;
      repeat (3) @(posedge clk);
      check({2'h0, scl_o, sda_o, scl_oe, sda_oe, done, nack}, 8'h00);
      check({5'h00, sel}, 8'h05);
      #1 nrst = 1'b1;
      foreach (rows[i]) begin
         take(rows[i].cmd, rows[i].d0);
         while (done !== 1'b1) @(negedge clk);
         check({7'h00, nack}, {7'h00, rows[i].nk});
         check(8'(rq.size()), (rows[i].cmd.rd && !rows[i].nk) ? 8'(rows[i].cmd.len) + 8'h01 : 8'h00);
         foreach (rq[j]) check(rq[j], (j == 0) ? rows[i].r0 : rows[i].r1);
      end
      // second reset in the middle of a control byte
      take('{1'b0, 1'b0, 3'h5, 13'h0000, 5'h00}, 8'h00);
      repeat (1000) @(posedge clk);
      #1 nrst = 1'b0;
      repeat (3) @(posedge clk);
      check({6'h00, scl_oe, sda_oe}, 8'h00);
      #1 nrst = 1'b1;
      // protect drops after the take but must still hold for this write
      prot_in = 1'b1;
      take('{1'b0, 1'b0, 3'h5, 13'h1801, 5'h00}, 8'h77);
      prot_in = 1'b0;
      while (done !== 1'b1) @(negedge clk);
      check({6'h00, prot_out, nack}, 8'h02);
      check(dev.mem[13'h1801], 8'hFF);
      check({7'h00, dev.busy}, 8'h00);
      while (cmd_ready !== 1'b1) @(negedge clk);
      @(negedge clk);
      check({6'h00, wdat_ready, prot_out}, 8'h02);
      finish_test();
   end
endmodule
